// File: design/cic_irq_ctrl.sv
// cpu interrupt controller: flags, enables, entry, return, context
//
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
module cic_irq_ctrl (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // register port
   input wire logic [11:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_we,
   input wire logic reg_re,
   output logic [7:0] reg_rdata,
   // event sources
   input wire logic tmr0_evt,
   input wire logic [7:0] periph_evt_1,
   input wire logic [7:0] periph_evt_2,
   input wire logic pin_change_any,
   input wire logic ext_pin,
   // processor core status and live context
   input wire logic return_from_isr_instr,
   input wire logic core_sleeping,
   input wire logic [7:0] ctx_w,
   input wire logic [7:0] ctx_status,
   input wire logic [7:0] ctx_bsr,
   input wire logic [15:0] ctx_fsr0,
   input wire logic [15:0] ctx_fsr1,
   input wire logic [6:0] ctx_pch,
   // redirection and restore to the core
   output logic irq_entry,
   output logic [14:0] irq_vector,
   output logic ctx_restore,
   output logic wake_req,
   output logic global_irq_enable,
   // shadow copies, restored on return
   output logic [7:0] shadow_w,
   output logic [7:0] shadow_status,
   output logic [7:0] shadow_bsr,
   output logic [15:0] shadow_fsr0,
   output logic [15:0] shadow_fsr1,
   output logic [6:0] shadow_pch
);

   logic q1, global_irq_enable_q, peripheral_group_enable_q;
   logic tmr0_enable_q, ext_pin_irq_enable_q, pin_change_enable_q;
   logic tmr0_flag_q, ext_pin_irq_flag_q, pin_change_summary_flag_q;
   logic ext_pin_edge_select_q, ext_pin_prev_q;
   logic [7:0] peripheral_irq_flags_1_q, peripheral_irq_flags_2_q;
   logic [7:0] peripheral_irq_enables_1_q, peripheral_irq_enables_2_q;
   logic [7:0] sh_w_q, sh_status_q, sh_bsr_q;
   logic [15:0] sh_fsr0_q, sh_fsr1_q;
   logic [6:0] sh_pch_q;
   logic irq_entry_q, ctx_restore_q, wake_req_q, wake_defer_q;
   logic [7:0] reg_rdata_q, rd_mux;
   logic ext_edge, core_req, periph_req, any_req, take, wr_ctl, wr_opt;

   // q1 enable from the phase sequencer
   cic_qphase cic_qphase_i (
      .clk(clk),
      .reset(reset),
      .q_phase_q(),
      .q1_q(q1)
   );

   assign wr_ctl = reg_we && (reg_addr == cic_pkg::OFS_CTL);
   assign wr_opt = reg_we && (reg_addr == cic_pkg::OFS_OPT);

   // selected edge on the pin; pin is clock synchronous
   assign ext_edge = ext_pin_edge_select_q ?
      (ext_pin && !ext_pin_prev_q) :
      (!ext_pin && ext_pin_prev_q);

   // request: flag and enable terms, group gate on peripheral terms
   assign core_req = (tmr0_flag_q && tmr0_enable_q) ||
      (ext_pin_irq_flag_q && ext_pin_irq_enable_q) ||
      (pin_change_summary_flag_q && pin_change_enable_q);
   assign periph_req = peripheral_group_enable_q &&
      (|(peripheral_irq_flags_1_q & peripheral_irq_enables_1_q) ||
      |(peripheral_irq_flags_2_q & peripheral_irq_enables_2_q));
   assign any_req = core_req || periph_req;

   // sampled once per instruction cycle at q1, whatever the
   // length of the running instruction, so latency is fixed
   assign take = q1 && global_irq_enable_q && any_req &&
      !core_sleeping && !wake_defer_q;

   // previous pin level for edge detection
   always_ff @(posedge clk) begin
      if (reset) begin
         ext_pin_prev_q <= 1'b0;
      end else begin
         ext_pin_prev_q <= ext_pin;
      end
   end

   // edge select lives in the option register
   always_ff @(posedge clk) begin
      if (reset) begin
         ext_pin_edge_select_q <= 1'b0;
      end else if (wr_opt) begin
         ext_pin_edge_select_q <= reg_wdata[cic_pkg::OPT_EDGE];
      end
   end

   // global enable: reset clears, entry clears, return sets
   always_ff @(posedge clk) begin
      if (reset) begin
         global_irq_enable_q <= 1'b0;
      end else if (take) begin
         global_irq_enable_q <= 1'b0;
      end else if (return_from_isr_instr) begin
         global_irq_enable_q <= 1'b1;
      end else if (wr_ctl) begin
         global_irq_enable_q <= reg_wdata[cic_pkg::CTL_GIE];
      end
   end

   // individual and group enables in the control register
   always_ff @(posedge clk) begin
      if (reset) begin
         peripheral_group_enable_q <= 1'b0;
         tmr0_enable_q <= 1'b0;
         ext_pin_irq_enable_q <= 1'b0;
         pin_change_enable_q <= 1'b0;
      end else if (wr_ctl) begin
         peripheral_group_enable_q <= reg_wdata[cic_pkg::CTL_PERIPHERAL_GROUP_ENABLE];
         tmr0_enable_q <= reg_wdata[cic_pkg::CTL_T0E];
         ext_pin_irq_enable_q <= reg_wdata[cic_pkg::CTL_EXE];
         pin_change_enable_q <= reg_wdata[cic_pkg::CTL_IOCE];
      end
   end

   // control flags: an event in the clearing cycle still sets
   always_ff @(posedge clk) begin
      if (reset) begin
         tmr0_flag_q <= 1'b0;
         ext_pin_irq_flag_q <= 1'b0;
      end else begin
         tmr0_flag_q <= (wr_ctl ? reg_wdata[cic_pkg::CTL_T0F] :
            tmr0_flag_q) || tmr0_evt;
         ext_pin_irq_flag_q <= (wr_ctl ? reg_wdata[cic_pkg::CTL_EXF] :
            ext_pin_irq_flag_q) || ext_edge;
      end
   end

   // summary flag follows the pin flags, not writable
   always_ff @(posedge clk) begin
      if (reset) begin
         pin_change_summary_flag_q <= 1'b0;
      end else begin
         pin_change_summary_flag_q <= pin_change_any;
      end
   end

   // peripheral flags, set wins over a software clear
   always_ff @(posedge clk) begin
      if (reset) begin
         peripheral_irq_flags_1_q <= cic_pkg::RST_BYTE;
         peripheral_irq_flags_2_q <= cic_pkg::RST_BYTE;
      end else begin
         peripheral_irq_flags_1_q <=
            ((reg_we && (reg_addr == cic_pkg::OFS_FLG1)) ?
            reg_wdata : peripheral_irq_flags_1_q) | periph_evt_1;
         peripheral_irq_flags_2_q <= cic_pkg::FLG2_MASK &
            (((reg_we && (reg_addr == cic_pkg::OFS_FLG2)) ?
            reg_wdata : peripheral_irq_flags_2_q) | periph_evt_2);
      end
   end

   // peripheral enables, cleared by reset
   always_ff @(posedge clk) begin
      if (reset) begin
         peripheral_irq_enables_1_q <= cic_pkg::RST_BYTE;
         peripheral_irq_enables_2_q <= cic_pkg::RST_BYTE;
      end else begin
         if (reg_we && (reg_addr == cic_pkg::OFS_EN1)) begin
            peripheral_irq_enables_1_q <= reg_wdata;
         end
         if (reg_we && (reg_addr == cic_pkg::OFS_EN2)) begin
            peripheral_irq_enables_2_q <= reg_wdata & cic_pkg::FLG2_MASK;
         end
      end
   end

   // entry pulse: core flushes the prefetch, pushes pc, loads vector
   always_ff @(posedge clk) begin
      if (reset) begin
         irq_entry_q <= 1'b0;
      end else begin
         irq_entry_q <= take;
      end
   end

   // restore pulse one cycle after the return instruction
   always_ff @(posedge clk) begin
      if (reset) begin
         ctx_restore_q <= 1'b0;
      end else begin
         ctx_restore_q <= return_from_isr_instr;
      end
   end

   // wake: any enabled pending flag, global enable not needed;
   // the global enable decides at q1 whether to branch once awake
   always_ff @(posedge clk) begin
      if (reset) begin
         wake_req_q <= 1'b0;
      end else begin
         wake_req_q <= core_sleeping && any_req;
      end
   end

   // skip the first q1 after waking so the instruction that
   // follows sleep runs before the branch
   always_ff @(posedge clk) begin
      if (reset) begin
         wake_defer_q <= 1'b0;
      end else if (wake_req_q) begin
         wake_defer_q <= 1'b1;
      end else if (q1 && !core_sleeping) begin
         wake_defer_q <= 1'b0;
      end
   end

   // shadow working and status; entry wins over a software write.
   // timeout and powerdown are not saved, the core keeps its own
   always_ff @(posedge clk) begin
      if (reset) begin
         sh_w_q <= cic_pkg::RST_BYTE;
         sh_status_q <= cic_pkg::RST_BYTE;
      end else if (take) begin
         sh_w_q <= ctx_w;
         sh_status_q <= ctx_status & cic_pkg::STATUS_SAVE_MASK;
      end else begin
         if (reg_we && (reg_addr == cic_pkg::OFS_SH_W)) begin
            sh_w_q <= reg_wdata;
         end
         if (reg_we && (reg_addr == cic_pkg::OFS_SH_STATUS)) begin
            sh_status_q <= reg_wdata & cic_pkg::STATUS_SAVE_MASK;
         end
      end
   end

   // shadow bank select and pc high latch, otherwise written by software or held
   always_ff @(posedge clk) begin
      if (reset) begin
         sh_bsr_q <= cic_pkg::RST_BYTE;
         sh_pch_q <= cic_pkg::RST_PCH;
      end else if (take) begin
         sh_bsr_q <= ctx_bsr;
         sh_pch_q <= ctx_pch;
      end else begin
         if (reg_we && (reg_addr == cic_pkg::OFS_SH_BSR)) begin
            sh_bsr_q <= reg_wdata;
         end
         if (reg_we && (reg_addr == cic_pkg::OFS_SH_PCH)) begin
            sh_pch_q <= reg_wdata[cic_pkg::PCH_W-1:0];
         end
      end
   end

   // shadow file select pair, byte wide writes
   always_ff @(posedge clk) begin
      if (reset) begin
         sh_fsr0_q <= {cic_pkg::RST_BYTE, cic_pkg::RST_BYTE};
         sh_fsr1_q <= {cic_pkg::RST_BYTE, cic_pkg::RST_BYTE};
      end else if (take) begin
         sh_fsr0_q <= ctx_fsr0;
         sh_fsr1_q <= ctx_fsr1;
      end else if (reg_we) begin
         if (reg_addr == cic_pkg::OFS_SH_FSR0L) begin
            sh_fsr0_q[7:0] <= reg_wdata;
         end
         if (reg_addr == cic_pkg::OFS_SH_FSR0H) begin
            sh_fsr0_q[15:8] <= reg_wdata;
         end
         if (reg_addr == cic_pkg::OFS_SH_FSR1L) begin
            sh_fsr1_q[7:0] <= reg_wdata;
         end
         if (reg_addr == cic_pkg::OFS_SH_FSR1H) begin
            sh_fsr1_q[15:8] <= reg_wdata;
         end
      end
   end

   // read mux; unmapped addresses read as zero
   always_comb begin
      rd_mux = cic_pkg::RST_BYTE;
      unique case (reg_addr)
         cic_pkg::OFS_CTL: begin
            rd_mux = {global_irq_enable_q, peripheral_group_enable_q,
               tmr0_enable_q, ext_pin_irq_enable_q, pin_change_enable_q,
               tmr0_flag_q, ext_pin_irq_flag_q,
               pin_change_summary_flag_q};
         end
         cic_pkg::OFS_FLG1: rd_mux = peripheral_irq_flags_1_q;
         cic_pkg::OFS_FLG2: rd_mux = peripheral_irq_flags_2_q;
         cic_pkg::OFS_EN1: rd_mux = peripheral_irq_enables_1_q;
         cic_pkg::OFS_EN2: rd_mux = peripheral_irq_enables_2_q;
         cic_pkg::OFS_OPT: rd_mux[cic_pkg::OPT_EDGE] = ext_pin_edge_select_q;
         cic_pkg::OFS_SH_W: rd_mux = sh_w_q;
         cic_pkg::OFS_SH_STATUS: rd_mux = sh_status_q;
         cic_pkg::OFS_SH_BSR: rd_mux = sh_bsr_q;
         cic_pkg::OFS_SH_FSR0L: rd_mux = sh_fsr0_q[7:0];
         cic_pkg::OFS_SH_FSR0H: rd_mux = sh_fsr0_q[15:8];
         cic_pkg::OFS_SH_FSR1L: rd_mux = sh_fsr1_q[7:0];
         cic_pkg::OFS_SH_FSR1H: rd_mux = sh_fsr1_q[15:8];
         cic_pkg::OFS_SH_PCH: rd_mux = {1'b0, sh_pch_q};
         default: rd_mux = cic_pkg::RST_BYTE;
      endcase
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge clk) begin
      if (reset) begin
         reg_rdata_q <= cic_pkg::RST_BYTE;
      end else if (reg_re) begin
         reg_rdata_q <= rd_mux;
      end else begin
         reg_rdata_q <= cic_pkg::RST_BYTE;
      end
   end

   // outputs, straight from flip-flops except the constant vector
   assign reg_rdata = reg_rdata_q;
   assign irq_entry = irq_entry_q;
   assign irq_vector = cic_pkg::IRQ_VECTOR;
   assign ctx_restore = ctx_restore_q;
   assign wake_req = wake_req_q;
   assign global_irq_enable = global_irq_enable_q;
   assign shadow_w = sh_w_q;
   assign shadow_status = sh_status_q;
   assign shadow_bsr = sh_bsr_q;
   assign shadow_fsr0 = sh_fsr0_q;
   assign shadow_fsr1 = sh_fsr1_q;
   assign shadow_pch = sh_pch_q;

endmodule

// File: design/cic_pkg.sv
// shared constants of the cpu interrupt controller
package cic_pkg;

   // register bus geometry
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;

   // register offsets, bank 0 block
   localparam logic [11:0] OFS_CTL = 12'h0010;
   localparam logic [11:0] OFS_FLG1 = 12'h0011;
   localparam logic [11:0] OFS_FLG2 = 12'h0012;
   localparam logic [11:0] OFS_EN1 = 12'h0013;
   localparam logic [11:0] OFS_EN2 = 12'h0014;
   localparam logic [11:0] OFS_OPT = 12'h0015;

   // shadow registers, bank 31
   localparam logic [11:0] OFS_SH_W = 12'h0F84;
   localparam logic [11:0] OFS_SH_STATUS = 12'h0F85;
   localparam logic [11:0] OFS_SH_BSR = 12'h0F86;
   localparam logic [11:0] OFS_SH_FSR0L = 12'h0F87;
   localparam logic [11:0] OFS_SH_FSR0H = 12'h0F88;
   localparam logic [11:0] OFS_SH_FSR1L = 12'h0F89;
   localparam logic [11:0] OFS_SH_FSR1H = 12'h0F8A;
   localparam logic [11:0] OFS_SH_PCH = 12'h0F8B;

   // control register bit positions
   localparam int CTL_GIE = 7;
   localparam int CTL_PERIPHERAL_GROUP_ENABLE = 6;
   localparam int CTL_T0E = 5;
   localparam int CTL_EXE = 4;
   localparam int CTL_IOCE = 3;
   localparam int CTL_T0F = 2;
   localparam int CTL_EXF = 1;
   localparam int CTL_IOCF = 0;

   // option register: edge select bit
   localparam int OPT_EDGE = 6;

   // implemented bits of flag/enable register 2
   localparam logic [7:0] FLG2_MASK = 8'h00EF;
   // status bits saved; timeout and powerdown excluded
   localparam logic [7:0] STATUS_SAVE_MASK = 8'h00E7;

   // reset values
   localparam logic [7:0] RST_BYTE = 8'h0000;
   localparam logic [6:0] RST_PCH = 7'h00;

   // widths and the entry vector
   localparam int PCH_W = 7;
   localparam int PC_W = 15;
   localparam logic [14:0] IRQ_VECTOR = 15'h0004;

   // q phase sequencing, four phases per instruction cycle
   localparam logic [1:0] Q_FIRST = 2'h0;
   localparam logic [1:0] Q_LAST = 2'h3;

endpackage

// File: design/cic_qphase.sv
// q phase sequencer: four clocks per instruction cycle
`timescale 1ns/1ns
module cic_qphase (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // phase outputs
   output logic [1:0] q_phase_q,
   output logic q1_q
);

   // phase counter wraps after q4
   always_ff @(posedge clk) begin
      if (reset) begin
         q_phase_q <= cic_pkg::Q_FIRST;
      end else if (q_phase_q == cic_pkg::Q_LAST) begin
         q_phase_q <= cic_pkg::Q_FIRST;
      end else begin
         q_phase_q <= q_phase_q + 2'h1;
      end
   end

   // q1 enable: high exactly while the phase is q1
   always_ff @(posedge clk) begin
      if (reset) begin
         q1_q <= 1'b0;
      end else begin
         q1_q <= (q_phase_q == cic_pkg::Q_LAST);
      end
   end

endmodule

// File: tb/cic_irq_ctrl_properties.sv
// port checker for the cpu interrupt controller
`timescale 1ns/1ns
module cic_irq_ctrl_properties (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // register port
   input wire logic [11:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_we,
   input wire logic reg_re,
   input wire logic [7:0] reg_rdata,
   // core side
   input wire logic return_from_isr_instr,
   input wire logic core_sleeping,
   input wire logic [7:0] ctx_w,
   input wire logic [7:0] ctx_status,
   input wire logic [6:0] ctx_pch,
   input wire logic irq_entry,
   input wire logic ctx_restore,
   input wire logic wake_req,
   input wire logic global_irq_enable,
   input wire logic [7:0] shadow_w,
   input wire logic [7:0] shadow_status,
   input wire logic [6:0] shadow_pch
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   // all properties watch only the controller's ports
   property p_reset_quiet;
      $fell(reset) |-> !global_irq_enable && !irq_entry && shadow_w == 0;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet)
      else $error("enabled after reset");
   property p_entry;
      irq_entry |-> !global_irq_enable ##1 !irq_entry;
   endproperty
   a_entry: assert property (p_entry)
      else $error("entry pulse or enable wrong");
   property p_gated;
      irq_entry |-> $past(global_irq_enable) && !$past(core_sleeping);
   endproperty
   a_gated: assert property (p_gated)
      else $error("entry without enable or while asleep");
   property p_save;
      irq_entry |-> shadow_w == $past(ctx_w) && shadow_pch == $past(ctx_pch)
         && shadow_status == ($past(ctx_status) & cic_pkg::STATUS_SAVE_MASK);
   endproperty
   a_save: assert property (p_save)
      else $error("context save wrong");
   property p_return;
      return_from_isr_instr |=> ctx_restore
         && (global_irq_enable || irq_entry);
   endproperty
   a_return: assert property (p_return)
      else $error("return did not restore");
   // a software write is the only other way a shadow may move
   property p_hold;
      !irq_entry && !$past(reg_we) && !$past(reset) |-> $stable(shadow_w)
         && $stable(shadow_pch);
   endproperty
   a_hold: assert property (p_hold)
      else $error("shadow moved");
   property p_sh_read;
      reg_re && reg_addr == cic_pkg::OFS_SH_W |=> reg_rdata == $past(shadow_w);
   endproperty
   a_sh_read: assert property (p_sh_read)
      else $error("shadow read wrong");
   property p_ctl_write;
      reg_we && reg_addr == cic_pkg::OFS_CTL |=> irq_entry
         || global_irq_enable == $past(reg_wdata[cic_pkg::CTL_GIE]);
   endproperty
   a_ctl_write: assert property (p_ctl_write)
      else $error("global enable write lost");
   property p_wake;
      wake_req |-> $past(core_sleeping);
   endproperty
   a_wake: assert property (p_wake)
      else $error("wake while awake");
   c_entry: cover property (irq_entry);
   c_restore: cover property (ctx_restore);
   c_wake: cover property (wake_req);
endmodule

bind cic_irq_ctrl cic_irq_ctrl_properties cic_irq_ctrl_properties_i (
   .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
   .return_from_isr_instr(return_from_isr_instr),
   .core_sleeping(core_sleeping), .ctx_w(ctx_w), .ctx_status(ctx_status),
   .ctx_pch(ctx_pch), .irq_entry(irq_entry), .ctx_restore(ctx_restore),
   .wake_req(wake_req), .global_irq_enable(global_irq_enable),
   .shadow_w(shadow_w), .shadow_status(shadow_status),
   .shadow_pch(shadow_pch));

// File: tb/cic_core_model.sv
// processor core model: live context, return and sleep
`timescale 1ns/1ns
module cic_core_model (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // bench commands
   input wire logic ret_cmd,
   input wire logic sleep_cmd,
   // from the controller
   input wire logic ctx_restore,
   input wire logic wake_req,
   input wire logic [7:0] shadow_w,
   // to the controller
   output logic return_from_isr_instr,
   output logic core_sleeping,
   output logic [7:0] ctx_w,
   output logic [7:0] ctx_status,
   output logic [7:0] ctx_bsr,
   output logic [15:0] ctx_fsr0,
   output logic [15:0] ctx_fsr1,
   output logic [6:0] ctx_pch
);
   logic [7:0] w_q;
   // context moves every cycle, so a save taken one cycle off shows up
   always_ff @(posedge clk) begin
      if (reset) begin
         w_q <= 8'h00;
      end else if (ctx_restore) begin
         w_q <= shadow_w;
      end else begin
         w_q <= w_q + 8'h01;
      end
   end
   // status drives timeout and powerdown bits too, to prove they are dropped
   assign ctx_w = w_q;
   assign ctx_status = ~w_q;
   assign ctx_bsr = w_q ^ 8'h5A;
   assign ctx_fsr0 = {w_q, ~w_q};
   assign ctx_fsr1 = {~w_q, w_q};
   assign ctx_pch = w_q[7:1];
   // return executes one cycle after the bench asks for it
   always_ff @(posedge clk) begin
      if (reset) begin
         return_from_isr_instr <= 1'b0;
      end else begin
         return_from_isr_instr <= ret_cmd;
      end
   end
   // sleep holds until the controller requests a wake
   always_ff @(posedge clk) begin
      if (reset || wake_req) begin
         core_sleeping <= 1'b0;
      end else if (sleep_cmd) begin
         core_sleeping <= 1'b1;
      end
   end
endmodule

// File: tb/test_cpu_interrupt_controller.sv
// self-checking bench for the cpu interrupt controller
`timescale 1ns/1ns
module test_cpu_interrupt_controller;
   logic clk, reset, reg_we, reg_re, tmr0_evt, pin_change_any, ext_pin;
   logic ret_cmd, sleep_cmd, return_from_isr_instr, core_sleeping;
   logic irq_entry, ctx_restore, wake_req, global_irq_enable;
   logic [11:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, periph_evt_1, periph_evt_2, ctx_w;
   logic [7:0] ctx_status, ctx_bsr, shadow_w, shadow_status, shadow_bsr;
   logic [15:0] ctx_fsr0, ctx_fsr1, shadow_fsr0, shadow_fsr1;
   logic [6:0] ctx_pch, shadow_pch;
   logic [14:0] irq_vector;
   logic [7:0] v, acc1, acc2;
   int miscompares = 0;
   int check_count = 0;
   int entries = 0;
   int wakes = 0;
   int i, k;

   cic_irq_ctrl cic_irq_ctrl_i (.clk(clk), .reset(reset),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
      .reg_re(reg_re), .reg_rdata(reg_rdata), .tmr0_evt(tmr0_evt),
      .periph_evt_1(periph_evt_1), .periph_evt_2(periph_evt_2),
      .pin_change_any(pin_change_any), .ext_pin(ext_pin),
      .return_from_isr_instr(return_from_isr_instr),
      .core_sleeping(core_sleeping), .ctx_w(ctx_w), .ctx_status(ctx_status),
      .ctx_bsr(ctx_bsr), .ctx_fsr0(ctx_fsr0), .ctx_fsr1(ctx_fsr1),
      .ctx_pch(ctx_pch), .irq_entry(irq_entry), .irq_vector(irq_vector),
      .ctx_restore(ctx_restore), .wake_req(wake_req),
      .global_irq_enable(global_irq_enable), .shadow_w(shadow_w),
      .shadow_status(shadow_status), .shadow_bsr(shadow_bsr),
      .shadow_fsr0(shadow_fsr0), .shadow_fsr1(shadow_fsr1),
      .shadow_pch(shadow_pch));
   cic_core_model cic_core_model_i (.clk(clk), .reset(reset),
      .ret_cmd(ret_cmd), .sleep_cmd(sleep_cmd), .ctx_restore(ctx_restore),
      .wake_req(wake_req), .shadow_w(shadow_w),
      .return_from_isr_instr(return_from_isr_instr),
      .core_sleeping(core_sleeping), .ctx_w(ctx_w), .ctx_status(ctx_status),
      .ctx_bsr(ctx_bsr), .ctx_fsr0(ctx_fsr0), .ctx_fsr1(ctx_fsr1),
      .ctx_pch(ctx_pch));

   // free-running 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // count redirections and wakes, since both can land inside a bus task
   always @(posedge clk) begin
      if (irq_entry === 1'b1) entries <= entries + 1;
      if (wake_req === 1'b1 && core_sleeping === 1'b1) wakes <= wakes + 1;
   end

   task automatic wrap_up();
      if (miscompares == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(string n, logic [7:0] e, logic [7:0] g);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   // bus tasks leave one idle edge so a strobe is never set twice at once
   task automatic wr(logic [11:0] a, logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_we <= 1'b1;
      @(posedge clk);
      reg_we <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rdc(logic [11:0] a, logic [7:0] e);
      reg_addr <= a;
      reg_re <= 1'b1;
      @(posedge clk);
      reg_re <= 1'b0;
      #1;
      chk($sformatf("reg %h", a), e, reg_rdata);
      @(posedge clk);
   endtask
   task automatic evt(logic t, logic [7:0] a, logic [7:0] b);
      tmr0_evt <= t;
      periph_evt_1 <= a;
      periph_evt_2 <= b;
      @(posedge clk);
      tmr0_evt <= 1'b0;
      periph_evt_1 <= 8'h00;
      periph_evt_2 <= 8'h00;
      @(posedge clk);
   endtask
   task automatic pin(logic l);
      ext_pin <= l;
      repeat (8) @(posedge clk);
   endtask
   task automatic idle();
      repeat (12) @(posedge clk);
   endtask
   task automatic wait_n(int n);
      for (k = 0; k < 10 && entries != n; k++) @(posedge clk);
      chk("entries", 8'(n), 8'(entries));
      if (entries != n) wrap_up();
   endtask
   task automatic isr_exit();
      ret_cmd <= 1'b1;
      @(posedge clk);
      ret_cmd <= 1'b0;
      for (k = 0; k < 6 && ctx_restore !== 1'b1; k++) @(posedge clk);
      chk("ctx_restore", 8'h01, {7'h00, ctx_restore});
      if (ctx_restore !== 1'b1) wrap_up();
      @(posedge clk);
   endtask

   initial begin
      {reset, reg_we, reg_re, tmr0_evt, ret_cmd, sleep_cmd} = 6'h3F & 6'h20;
      {pin_change_any, ext_pin, reg_addr, reg_wdata} = '0;
      {periph_evt_1, periph_evt_2} = 16'h0000;
      void'($urandom(64535));
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      chk("gie", 8'h00, {7'h00, global_irq_enable});
      rdc(cic_pkg::OFS_CTL, 8'h00);
      rdc(12'h0700, 8'h00);
      // first pass drives only the unimplemented flag bit of register 2
      acc1 = 8'h00;
      acc2 = 8'h00;
      for (i = 0; i < 5; i++) begin
         v = (i == 0) ? 8'hEF : 8'($urandom);
         acc1 = acc1 | v;
         acc2 = acc2 | (~v & cic_pkg::FLG2_MASK);
         evt(1'b1, v, ~v);
      end
      rdc(cic_pkg::OFS_FLG1, acc1);
      rdc(cic_pkg::OFS_FLG2, acc2);
      rdc(cic_pkg::OFS_CTL, 8'h04);
      chk("entries", 8'h00, 8'(entries));
      wr(cic_pkg::OFS_EN1, 8'hFF);
      wr(cic_pkg::OFS_CTL, 8'h80);
      idle();
      chk("entries", 8'h00, 8'(entries));
      wr(cic_pkg::OFS_CTL, 8'hC0);
      wait_n(1);
      chk("gie", 8'h00, {7'h00, global_irq_enable});
      chk("vector", 8'h04, irq_vector[7:0]);
      chk("vector_hi", 8'h00, irq_vector[14:7]);
      v = shadow_status & ~cic_pkg::STATUS_SAVE_MASK;
      chk("status_drop", 8'h00, v);
      // service routine polls, rewrites a shadow, clears and returns
      rdc(cic_pkg::OFS_FLG1, acc1);
      // bank select and file select shadow bytes through the bus and out on their ports
      for (i = 0; i < 5; i++) begin
         v = 8'($urandom);
         wr(cic_pkg::OFS_SH_BSR + 12'(i), v);
         rdc(cic_pkg::OFS_SH_BSR + 12'(i), v);
         acc1 = 8'({shadow_fsr1, shadow_fsr0, shadow_bsr} >> 8 * i);
         chk("shadow_out", v, acc1);
      end
      v = 8'($urandom);
      wr(cic_pkg::OFS_SH_W, v);
      rdc(cic_pkg::OFS_SH_W, v);
      wr(cic_pkg::OFS_FLG1, 8'h00);
      isr_exit();
      chk("shadow_w", v, shadow_w);
      chk("gie", 8'h01, {7'h00, global_irq_enable});
      idle();
      chk("entries", 8'h01, 8'(entries));
      // a pending flag waits for the global enable
      wr(cic_pkg::OFS_CTL, 8'h40);
      wr(cic_pkg::OFS_EN2, 8'hFF);
      idle();
      chk("entries", 8'h01, 8'(entries));
      wr(cic_pkg::OFS_CTL, 8'hC0);
      wait_n(2);
      wr(cic_pkg::OFS_FLG2, 8'h00);
      isr_exit();
      wr(cic_pkg::OFS_EN1, 8'h00);
      wr(cic_pkg::OFS_EN2, 8'h00);
      // both edge selections: opposite edge ignored, chosen edge flags
      for (i = 0; i < 2; i++) begin
         pin(i[0]);
         wr(cic_pkg::OFS_CTL, 8'h00);
         wr(cic_pkg::OFS_OPT, {1'b0, i[0], 6'h00});
         pin(~i[0]);
         rdc(cic_pkg::OFS_CTL, 8'h00);
         pin(i[0]);
         rdc(cic_pkg::OFS_CTL, 8'h02);
      end
      wr(cic_pkg::OFS_CTL, 8'h90);
      pin(1'b0);
      ext_pin <= 1'b1;
      wait_n(3);
      wr(cic_pkg::OFS_CTL, 8'h10);
      isr_exit();
      // the change summary follows its source and ignores writes
      pin_change_any <= 1'b1;
      @(posedge clk);
      rdc(cic_pkg::OFS_CTL, 8'h91);
      wr(cic_pkg::OFS_CTL, 8'h90);
      rdc(cic_pkg::OFS_CTL, 8'h91);
      pin_change_any <= 1'b0;
      @(posedge clk);
      rdc(cic_pkg::OFS_CTL, 8'h90);
      // an enabled change summary redirects like any source
      wr(cic_pkg::OFS_CTL, 8'h88);
      pin_change_any <= 1'b1;
      wait_n(4);
      pin_change_any <= 1'b0;
      wr(cic_pkg::OFS_CTL, 8'h08);
      isr_exit();
      // wake with global enable clear continues, with it set redirects
      for (i = 0; i < 2; i++) begin
         wr(cic_pkg::OFS_CTL, {i[0], 7'h20});
         sleep_cmd <= 1'b1;
         @(posedge clk);
         sleep_cmd <= 1'b0;
         evt(1'b1, 8'h00, 8'h00);
         idle();
         chk("wakes", 8'(i + 1), 8'(wakes));
         chk("entries", 8'(i + 4), 8'(entries));
      end
      wr(cic_pkg::OFS_CTL, 8'h20);
      isr_exit();
      wrap_up();
   end
endmodule
